//--- hdl/pcd_pin_mux.sv
// Port C low pins and port D pin function select with APB registers
// ------------------------------------------------------------------
// Summary of operation
// - Port C pin 3: GPIO, SPI0 data out 0, or audio data out.
// - Port C pin 2: GPIO, SPI0 data in 0, or audio data in.
// - Port C pin 1: GPIO, SPI0 clock, or audio bit clock.
// - Port C pin 0: GPIO, SPI0 select 0, or audio word clock.
// - Port D register is read/write at 0x3C, resets to zero.
// - Bits 31:16 enable the input Schmitt trigger per port D pin.
// - Bits 15:0 select each port D pin; clear means GPIO.
// - Port D select bit 15 routes UART2 transmit data to pin 15.
// - Port D select bit 14 routes pin 14 receive data to UART2.
// - Port D select bit 13 routes SPI3 out line 1 to pin 13.
// - Port D select bit 12 routes pin 12 to SPI3 in line 1.
// - Port D select bit 11 routes SPI3 out line 0 to pin 11.
// - Port D select bit 10 routes pin 10 to SPI3 in line 0.
// ------------------------------------------------------------------
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module pcd_pin_mux (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [pcd_pkg::PCD_PC_PINS-1:0] pad_c_in,
   output logic [pcd_pkg::PCD_PC_PINS-1:0] pad_c_out,
   output logic [pcd_pkg::PCD_PC_PINS-1:0] pad_c_oe_n,
   input wire logic [pcd_pkg::PCD_PC_PINS-1:0] gpio_c_out,
   input wire logic [pcd_pkg::PCD_PC_PINS-1:0] gpio_c_oe_n,
   output logic [pcd_pkg::PCD_PC_PINS-1:0] gpio_c_in,
   input wire logic [pcd_pkg::PCD_PC_PINS-1:0] spi_ch0_out,
   input wire logic [pcd_pkg::PCD_PC_PINS-1:0] spi_ch0_oe_n,
   output logic [pcd_pkg::PCD_PC_PINS-1:0] spi_ch0_in,
   input wire logic [pcd_pkg::PCD_PC_PINS-1:0] audio_out,
   input wire logic [pcd_pkg::PCD_PC_PINS-1:0] audio_oe_n,
   output logic [pcd_pkg::PCD_PC_PINS-1:0] audio_in,
   input wire logic [pcd_pkg::PCD_PD_PINS-1:0] pad_d_in,
   output logic [pcd_pkg::PCD_PD_PINS-1:0] pad_d_out,
   output logic [pcd_pkg::PCD_PD_PINS-1:0] pad_d_oe_n,
   output logic [pcd_pkg::PCD_PD_PINS-1:0] port_d_schmitt_enable,
   input wire logic [pcd_pkg::PCD_PD_PINS-1:0] gpio_d_out,
   input wire logic [pcd_pkg::PCD_PD_PINS-1:0] gpio_d_oe_n,
   output logic [pcd_pkg::PCD_PD_PINS-1:0] gpio_d_in,
   input wire logic [pcd_pkg::PCD_PD_PINS-1:0] periph_d_out,
   input wire logic [pcd_pkg::PCD_PD_PINS-1:0] periph_d_oe_n,
   output logic [pcd_pkg::PCD_PD_PINS-1:0] periph_d_in
);
   import pcd_pkg::*;

   localparam int CP = PCD_PC_PINS;
   localparam int DP = PCD_PD_PINS;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] apply_strobe(input logic [31:0] old_val,
                                                input logic [31:0] new_val,
                                                input logic [3:0] strb);
      logic [31:0] res;
      res = old_val;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = new_val[b*8 +: 8];
         end
      end
      return res;
   endfunction : apply_strobe

   function automatic pcd_fn_t pc_fn(input logic alt_bit, input logic sel_bit);
      pcd_fn_t fn;
      if (!sel_bit) begin
         fn = PCD_FN_GPIO;
      end else if (alt_bit) begin
         fn = PCD_FN_AUDIO;
      end else begin
         fn = PCD_FN_SPI;
      end
      return fn;
   endfunction : pc_fn

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [CP-1:0] port_c_function_select;
   logic [CP-1:0] alternate_function_select;
   logic [DP-1:0] port_d_function_select;
   logic [DP-1:0] schmitt;
   logic [31:0] c_word;
   logic [31:0] alt_word;
   logic [31:0] d_word;
   logic [31:0] next_c_word, next_alt_word;
   logic hit_c;
   logic hit_alt;
   logic hit_d;
   logic mapped;
   logic wr_access;

   always_comb begin
      c_word = PCD_PORT_C_SEL_RESET;
      alt_word = PCD_ALT_SEL_RESET;
      c_word[PCD_PC_SEL_LSB +: CP] = port_c_function_select;
      alt_word[PCD_ALT_PC_LSB +: CP] = alternate_function_select;
      d_word = {schmitt, port_d_function_select};
      next_c_word = apply_strobe(c_word, pwdata, pstrb);
      next_alt_word = apply_strobe(alt_word, pwdata, pstrb);
   end

   assign hit_c = (paddr == PCD_PORT_C_SEL_OFFSET);
   assign hit_alt = (paddr == PCD_ALT_SEL_OFFSET);
   assign hit_d = (paddr == PCD_PORT_D_OFFSET);
   assign mapped = hit_c | hit_alt | hit_d;
   assign wr_access = psel & penable & pwrite & mapped;

   // ----------------------------------------------------------------
   // APB slave: zero wait states, error on unmapped address
   // ----------------------------------------------------------------
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   always_comb begin
      if (hit_d) begin
         prdata = d_word;
      end else if (hit_c) begin
         prdata = c_word;
      end else if (hit_alt) begin
         prdata = alt_word;
      end else begin
         prdata = 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_d_function_select <= PCD_PORT_D_RESET[PCD_PD_SEL_LSB +: DP];
         schmitt <= PCD_PORT_D_RESET[PCD_PD_SCHMITT_LSB +: DP];
      end else if (wr_access && hit_d) begin
         {schmitt, port_d_function_select} <= apply_strobe(d_word, pwdata, pstrb);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_c_function_select <= PCD_PORT_C_SEL_RESET[PCD_PC_SEL_LSB +: CP];
      end else if (wr_access && hit_c) begin
         port_c_function_select <= next_c_word[PCD_PC_SEL_LSB +: CP];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alternate_function_select <= PCD_ALT_SEL_RESET[PCD_ALT_PC_LSB +: CP];
      end else if (wr_access && hit_alt) begin
         alternate_function_select <= next_alt_word[PCD_ALT_PC_LSB +: CP];
      end
   end

   assign port_d_schmitt_enable = schmitt;

   // ----------------------------------------------------------------
   // Pad input synchronisers
   // ----------------------------------------------------------------
   logic [CP-1:0] pad_c_sync;
   logic [DP-1:0] pad_d_sync;

   pcd_sync2 #(.WIDTH(CP)) u_sync_c (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(pad_c_in),
      .sync_out(pad_c_sync)
   );

   pcd_sync2 #(.WIDTH(DP)) u_sync_d (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(pad_d_in),
      .sync_out(pad_d_sync)
   );

   // ----------------------------------------------------------------
   // Port C routing
   // ----------------------------------------------------------------
   logic [CP-1:0] next_pad_c_out;
   logic [CP-1:0] next_pad_c_oe_n;
   logic [CP-1:0] next_spi_ch0_in;
   logic [CP-1:0] next_audio_in;

   always_comb begin
      next_pad_c_out = gpio_c_out;
      next_pad_c_oe_n = gpio_c_oe_n;
      next_spi_ch0_in = '0;
      next_audio_in = '0;
      for (int i = 0; i < CP; i++) begin
         case (pc_fn(alternate_function_select[i], port_c_function_select[i]))
            PCD_FN_SPI: begin
               next_pad_c_out[i] = spi_ch0_out[i];
               next_pad_c_oe_n[i] = spi_ch0_oe_n[i];
               next_spi_ch0_in[i] = pad_c_sync[i];
            end
            PCD_FN_AUDIO: begin
               next_pad_c_out[i] = audio_out[i];
               next_pad_c_oe_n[i] = audio_oe_n[i];
               next_audio_in[i] = pad_c_sync[i];
            end
            default: begin
               next_pad_c_out[i] = gpio_c_out[i];
               next_pad_c_oe_n[i] = gpio_c_oe_n[i];
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad_c_out <= '0;
         pad_c_oe_n <= '1;
         spi_ch0_in <= '0;
         audio_in <= '0;
         gpio_c_in <= '0;
      end else begin
         pad_c_out <= next_pad_c_out;
         pad_c_oe_n <= next_pad_c_oe_n;
         spi_ch0_in <= next_spi_ch0_in;
         audio_in <= next_audio_in;
         gpio_c_in <= pad_c_sync;
      end
   end

   // ----------------------------------------------------------------
   // Port D routing
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad_d_out <= '0;
         pad_d_oe_n <= '1;
         periph_d_in <= '0;
         gpio_d_in <= '0;
      end else begin
         pad_d_out <= (port_d_function_select & periph_d_out) |
                      (~port_d_function_select & gpio_d_out);
         pad_d_oe_n <= (port_d_function_select & periph_d_oe_n) |
                       (~port_d_function_select & gpio_d_oe_n);
         periph_d_in <= port_d_function_select & pad_d_sync;
         gpio_d_in <= pad_d_sync;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_pc3_audio;
      @(posedge pclk) disable iff (!presetn)
      (port_c_function_select[PCD_PC_DATA_OUT_PIN] && alternate_function_select[PCD_PC_DATA_OUT_PIN])
      |=> (pad_c_out[PCD_PC_DATA_OUT_PIN] == $past(audio_out[PCD_PC_DATA_OUT_PIN])) &&
          (pad_c_oe_n[PCD_PC_DATA_OUT_PIN] == $past(audio_oe_n[PCD_PC_DATA_OUT_PIN]));
   endproperty
   a_pc3_audio: assert property (p_pc3_audio) else $error("pc3 not audio out");

   property p_pc2_spi_in;
      @(posedge pclk) disable iff (!presetn)
      (port_c_function_select[PCD_PC_DATA_IN_PIN] && !alternate_function_select[PCD_PC_DATA_IN_PIN])
      |=> (spi_ch0_in[PCD_PC_DATA_IN_PIN] == $past(pad_c_sync[PCD_PC_DATA_IN_PIN])) &&
          !audio_in[PCD_PC_DATA_IN_PIN];
   endproperty
   a_pc2_spi_in: assert property (p_pc2_spi_in) else $error("pc2 not spi in");

   property p_pc1_spi_clock;
      @(posedge pclk) disable iff (!presetn)
      (port_c_function_select[PCD_PC_CLOCK_PIN] && !alternate_function_select[PCD_PC_CLOCK_PIN])
      |=> pad_c_out[PCD_PC_CLOCK_PIN] == $past(spi_ch0_out[PCD_PC_CLOCK_PIN]);
   endproperty
   a_pc1_spi_clock: assert property (p_pc1_spi_clock) else $error("pc1 not spi clock");

   property p_pc0_gpio;
      @(posedge pclk) disable iff (!presetn)
      !port_c_function_select[PCD_PC_WORD_PIN]
      |=> (pad_c_out[PCD_PC_WORD_PIN] == $past(gpio_c_out[PCD_PC_WORD_PIN])) &&
          !spi_ch0_in[PCD_PC_WORD_PIN] && !audio_in[PCD_PC_WORD_PIN];
   endproperty
   a_pc0_gpio: assert property (p_pc0_gpio) else $error("pc0 not gpio");

   property p_port_d_readback;
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && hit_d && pstrb == 4'hF)
      |=> d_word == $past(pwdata);
   endproperty
   a_port_d_readback: assert property (p_port_d_readback) else $error("port d readback wrong");

   property p_schmitt;
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && hit_d && pstrb == 4'hF)
      |=> port_d_schmitt_enable == $past(pwdata[31:16]);
   endproperty
   a_schmitt: assert property (p_schmitt) else $error("schmitt enable not updated");

   property p_port_d_route;
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> pad_d_out == (($past(port_d_function_select) & $past(periph_d_out)) |
                             (~$past(port_d_function_select) & $past(gpio_d_out)));
   endproperty
   a_port_d_route: assert property (p_port_d_route) else $error("port d routing wrong");

   property p_uart_tx;
      @(posedge pclk) disable iff (!presetn)
      port_d_function_select[PCD_PD_UART2_TX_PIN]
      |=> pad_d_oe_n[PCD_PD_UART2_TX_PIN] == $past(periph_d_oe_n[PCD_PD_UART2_TX_PIN]);
   endproperty
   a_uart_tx: assert property (p_uart_tx) else $error("uart tx not routed");

   property p_uart_rx;
      @(posedge pclk) disable iff (!presetn)
      port_d_function_select[PCD_PD_UART2_RX_PIN]
      |=> periph_d_in[PCD_PD_UART2_RX_PIN] == $past(pad_d_sync[PCD_PD_UART2_RX_PIN]);
   endproperty
   a_uart_rx: assert property (p_uart_rx) else $error("uart rx not routed");

   property p_spi3_out;
      @(posedge pclk) disable iff (!presetn)
      (port_d_function_select[PCD_PD_SPI3_OUT1_PIN] && port_d_function_select[PCD_PD_SPI3_OUT0_PIN])
      |=> (pad_d_out[PCD_PD_SPI3_OUT1_PIN] == $past(periph_d_out[PCD_PD_SPI3_OUT1_PIN])) &&
          (pad_d_out[PCD_PD_SPI3_OUT0_PIN] == $past(periph_d_out[PCD_PD_SPI3_OUT0_PIN]));
   endproperty
   a_spi3_out: assert property (p_spi3_out) else $error("spi3 out not routed");

   property p_spi3_in;
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> periph_d_in == ($past(port_d_function_select) & $past(pad_d_sync));
   endproperty
   a_spi3_in: assert property (p_spi3_in) else $error("port d inputs misrouted");

   property p_undefined_gpio;
      @(posedge pclk) disable iff (!presetn)
      (alternate_function_select[PCD_PC_DATA_OUT_PIN] && !port_c_function_select[PCD_PC_DATA_OUT_PIN])
      |=> (pad_c_oe_n[PCD_PC_DATA_OUT_PIN] == $past(gpio_c_oe_n[PCD_PC_DATA_OUT_PIN])) &&
          !audio_in[PCD_PC_DATA_OUT_PIN];
   endproperty
   a_undefined_gpio: assert property (p_undefined_gpio) else $error("undefined pc mode not gpio");

   property p_cov_audio;
      @(posedge pclk) disable iff (!presetn)
      port_c_function_select[PCD_PC_CLOCK_PIN] && alternate_function_select[PCD_PC_CLOCK_PIN];
   endproperty
   c_cov_audio: cover property (p_cov_audio);

   property p_cov_uart;
      @(posedge pclk) disable iff (!presetn)
      port_d_function_select[PCD_PD_UART2_TX_PIN] && port_d_function_select[PCD_PD_UART2_RX_PIN];
   endproperty
   c_cov_uart: cover property (p_cov_uart);

   property p_cov_error;
      @(posedge pclk) disable iff (!presetn)
      pslverr;
   endproperty
   c_cov_error: cover property (p_cov_error);

endmodule : pcd_pin_mux

`default_nettype wire

//--- common/pcd_pkg.sv
// Constants and types for the port C/D pin function select block
package pcd_pkg;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses from the system control base)
   // ----------------------------------------------------------------
   localparam logic [11:0] PCD_PORT_C_SEL_OFFSET = 12'h034;
   localparam logic [11:0] PCD_PORT_D_OFFSET = 12'h03C;
   localparam logic [11:0] PCD_ALT_SEL_OFFSET = 12'h050;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] PCD_PORT_C_SEL_RESET = 32'h0000_0000;
   localparam logic [31:0] PCD_PORT_D_RESET = 32'h0000_0000;
   localparam logic [31:0] PCD_ALT_SEL_RESET = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------
   localparam int PCD_PC_PINS = 4;
   localparam int PCD_PD_PINS = 16;
   localparam int PCD_PC_SEL_LSB = 0;
   localparam int PCD_ALT_PC_LSB = 5;
   localparam int PCD_PD_SEL_LSB = 0;
   localparam int PCD_PD_SCHMITT_LSB = 16;

   // ----------------------------------------------------------------
   // Port C pin roles and port D pin indices
   // ----------------------------------------------------------------
   localparam int PCD_PC_DATA_OUT_PIN = 3;
   localparam int PCD_PC_DATA_IN_PIN = 2;
   localparam int PCD_PC_CLOCK_PIN = 1;
   localparam int PCD_PC_WORD_PIN = 0;
   localparam int PCD_PD_UART2_TX_PIN = 15;
   localparam int PCD_PD_UART2_RX_PIN = 14;
   localparam int PCD_PD_SPI3_OUT1_PIN = 13;
   localparam int PCD_PD_SPI3_IN1_PIN = 12;
   localparam int PCD_PD_SPI3_OUT0_PIN = 11;
   localparam int PCD_PD_SPI3_IN0_PIN = 10;

   // ----------------------------------------------------------------
   // Port C pin functions
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PCD_FN_GPIO = 2'b00,
      PCD_FN_SPI = 2'b01,
      PCD_FN_AUDIO = 2'b10
   } pcd_fn_t;

endpackage : pcd_pkg

//--- hdl/pcd_sync2.sv
// Two-flop synchroniser for pad inputs
`timescale 1ns/1ps
`default_nettype none

module pcd_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;

   // ----------------------------------------------------------------
   // First stage feeds only the second
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end

endmodule : pcd_sync2

`default_nettype wire

//--- bench/pcd_far_side.sv
// Far-side model: peripheral controllers, GPIO controller and board pads
`timescale 1ns/1ps
`default_nettype none

module pcd_far_side (
   input wire logic [3:0] pad_c_out,
   input wire logic [3:0] pad_c_oe_n,
   input wire logic [15:0] pad_d_out,
   input wire logic [15:0] pad_d_oe_n,
   output logic [3:0] pad_c_in,
   output logic [3:0] gpio_c_out,
   output logic [3:0] gpio_c_oe_n,
   output logic [3:0] spi_ch0_out,
   output logic [3:0] spi_ch0_oe_n,
   output logic [3:0] audio_out,
   output logic [3:0] audio_oe_n,
   output logic [15:0] pad_d_in,
   output logic [15:0] gpio_d_out,
   output logic [15:0] gpio_d_oe_n,
   output logic [15:0] periph_d_out,
   output logic [15:0] periph_d_oe_n
);
   // ---------------------------------------------------------------
   // Sources: distinct patterns (SPI0 and audio enables both 4'h4) so most wrong routes show at the pads
   // ---------------------------------------------------------------
   assign gpio_c_out = 4'h3;
   assign gpio_c_oe_n = 4'h9;
   assign spi_ch0_out = 4'hA;
   assign spi_ch0_oe_n = 4'h4;
   assign audio_out = 4'h5;
   assign audio_oe_n = 4'h4;
   assign gpio_d_out = 16'h1234;
   assign gpio_d_oe_n = 16'h0FF0;
   assign periph_d_out = 16'hCB3D;
   assign periph_d_oe_n = 16'h54F0;
   // ---------------------------------------------------------------
   // Pads: board devices drive every pin the chip releases
   // ---------------------------------------------------------------
   assign pad_c_in = (~pad_c_oe_n & pad_c_out) | (pad_c_oe_n & 4'h6);
   assign pad_d_in = (~pad_d_oe_n & pad_d_out) | (pad_d_oe_n & 16'h5A69);
endmodule : pcd_far_side

`default_nettype wire

//--- bench/test_pcd_pin_mux.sv
// Self-checking testbench for the port C/D pin function select block
`timescale 1ns/1ps
`default_nettype none

module test_pcd_pin_mux;
   import pcd_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'h0;
   wire logic [31:0] prdata;
   wire logic pready, pslverr;
   wire logic [3:0] pc_in, pc_out, pc_oe, gc_out, gc_oe, gc_in, sp_out, sp_oe, sp_in;
   wire logic [3:0] au_out, au_oe, au_in;
   wire logic [15:0] pd_in, pd_out, pd_oe, schm, gd_out, gd_oe, gd_in, pe_out, pe_oe, pe_in;
   int mismatches = 0;
   int compares = 0;
   int cycles = 0;
   logic [3:0] csel [5] = '{4'h0, 4'hF, 4'hF, 4'h0, 4'h5};
   logic [3:0] calt [5] = '{4'h0, 4'h0, 4'hF, 4'hF, 4'h3};
   logic [15:0] dsel [5] = '{16'h0000, 16'hFC00, 16'h5555, 16'hAAAA, 16'hFFFF};
   logic [3:0] s, a;
   logic [15:0] m;

   always #10 pclk = ~pclk;

   pcd_pin_mux pcd_pin_mux_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pad_c_in(pc_in), .pad_c_out(pc_out), .pad_c_oe_n(pc_oe),
      .gpio_c_out(gc_out), .gpio_c_oe_n(gc_oe), .gpio_c_in(gc_in), .spi_ch0_out(sp_out),
      .spi_ch0_oe_n(sp_oe), .spi_ch0_in(sp_in), .audio_out(au_out), .audio_oe_n(au_oe),
      .audio_in(au_in), .pad_d_in(pd_in), .pad_d_out(pd_out), .pad_d_oe_n(pd_oe),
      .port_d_schmitt_enable(schm), .gpio_d_out(gd_out), .gpio_d_oe_n(gd_oe),
      .gpio_d_in(gd_in), .periph_d_out(pe_out), .periph_d_oe_n(pe_oe), .periph_d_in(pe_in));

   pcd_far_side pcd_far_side_inst (
      .pad_c_out(pc_out), .pad_c_oe_n(pc_oe), .pad_d_out(pd_out), .pad_d_oe_n(pd_oe),
      .pad_c_in(pc_in), .gpio_c_out(gc_out), .gpio_c_oe_n(gc_oe), .spi_ch0_out(sp_out),
      .spi_ch0_oe_n(sp_oe), .audio_out(au_out), .audio_oe_n(au_oe), .pad_d_in(pd_in),
      .gpio_d_out(gd_out), .gpio_d_oe_n(gd_oe), .periph_d_out(pe_out),
      .periph_d_oe_n(pe_oe));

   // ---------------------------------------------------------------
   // Reporting
   // ---------------------------------------------------------------
   task automatic end_of_test();
      $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string what);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s: expected %h got %h", $time, what, exp, got);
      end
   endtask : chk

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 4000) begin
         mismatches++;
         $display("[FAIL] %0t run did not complete", $time);
         end_of_test();
      end
   end

   // ---------------------------------------------------------------
   // APB master: entered just after a rising edge
   // ---------------------------------------------------------------
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
                      input logic [3:0] st, output logic [31:0] r, output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      pstrb <= st;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [11:0] ad, input logic [31:0] d, input logic [3:0] st);
      logic [31:0] r;
      logic e;
      apb(1'b1, ad, d, st, r, e);
   endtask : wr

   task automatic rd(input logic [11:0] ad, input logic [31:0] exp, input logic eerr);
      logic [31:0] r;
      logic e;
      apb(1'b0, ad, 32'h0000_0000, 4'h0, r, e);
      chk(exp, r, "read data");
      chk({31'h0, eerr}, {31'h0, e}, "slave error");
   endtask : rd

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (6) @(posedge pclk);
      chk(32'h0000_FFFF, {16'h0, pd_oe}, "pads released in reset");
      presetn <= 1'b1;
      @(posedge pclk);
      rd(PCD_PORT_D_OFFSET, 32'h0000_0000, 1'b0);
      rd(PCD_PORT_C_SEL_OFFSET, 32'h0000_0000, 1'b0);
      rd(PCD_ALT_SEL_OFFSET, 32'h0000_0000, 1'b0);
      wr(12'h040, 32'hFFFF_FFFF, 4'hF);
      rd(12'h040, 32'h0000_0000, 1'b1);
      $display("Test reset values done");
      wr(PCD_PORT_D_OFFSET, 32'hFFFF_FFFF, 4'hF);
      rd(PCD_PORT_D_OFFSET, 32'hFFFF_FFFF, 1'b0);
      chk(32'h0000_FFFF, {16'h0, schm}, "schmitt all");
      wr(PCD_PORT_D_OFFSET, 32'h1234_0000, 4'h8);
      rd(PCD_PORT_D_OFFSET, 32'h12FF_FFFF, 1'b0);
      chk(32'h0000_12FF, {16'h0, schm}, "schmitt merge");
      wr(PCD_PORT_C_SEL_OFFSET, 32'hFFFF_FFFF, 4'hF);
      rd(PCD_PORT_C_SEL_OFFSET, 32'h0000_000F, 1'b0);
      wr(PCD_ALT_SEL_OFFSET, 32'hFFFF_FFFF, 4'hF);
      rd(PCD_ALT_SEL_OFFSET, 32'h0000_01E0, 1'b0);
      $display("Test register access done");
      for (int i = 0; i < 5; i++) begin
         s = csel[i];
         a = calt[i];
         wr(PCD_PORT_C_SEL_OFFSET, {28'h0, s}, 4'hF);
         wr(PCD_ALT_SEL_OFFSET, {23'h0, a, 5'h0}, 4'hF);
         repeat (4) @(posedge pclk);
         chk({28'h0, (~s & gc_out) | (s & ~a & sp_out) | (s & a & au_out)},
             {28'h0, pc_out}, "port C out");
         chk({28'h0, (~s & gc_oe) | (s & ~a & sp_oe) | (s & a & au_oe)},
             {28'h0, pc_oe}, "port C enable");
         chk({28'h0, s & ~a & pc_in}, {28'h0, sp_in}, "spi input");
         chk({28'h0, s & a & pc_in}, {28'h0, au_in}, "audio input");
         chk({28'h0, pc_in}, {28'h0, gc_in}, "gpio C input");
      end
      $display("Test port C routing done");
      for (int i = 0; i < 5; i++) begin
         m = dsel[i];
         wr(PCD_PORT_D_OFFSET, {~m, m}, 4'hF);
         repeat (4) @(posedge pclk);
         chk({16'h0, ~m}, {16'h0, schm}, "schmitt");
         chk({16'h0, (m & pe_out) | (~m & gd_out)},
             {16'h0, pd_out}, "port D out");
         chk({16'h0, (m & pe_oe) | (~m & gd_oe)},
             {16'h0, pd_oe}, "port D enable");
         chk({16'h0, m & pd_in}, {16'h0, pe_in}, "periph input");
         chk({16'h0, pd_in}, {16'h0, gd_in}, "gpio D input");
      end
      $display("Test port D routing done");
      end_of_test();
   end
endmodule : test_pcd_pin_mux

`default_nettype wire
